// ==== hdl/fpsr_top.sv ====
// Primary status register with serial command decode, write gating and busy tracking.
`timescale 1ns/1ns
`default_nettype none
module fpsr_top
  import fpsr_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic SCK,
  input wire logic CS_N,
  input wire logic SI,
  input wire logic WP_N,
  input wire logic STATUS_PROTECT_HI,
  input wire logic [5:0] NV_STATUS,
  input wire logic OP_DONE,
  output logic SO,
  output logic SO_OE,
  output logic OP_START,
  output fpsr_op_s OP,
  output logic PROG_STB,
  output logic [7:0] PROG_BYTE,
  output logic [7:0] STATUS
);
  logic [3:0] pin_s;
  logic sck_s, csn_s, si_s, wpn_s;
  logic sck_q, csn_q, rd_q, so_q, pstb_q, vol_q, start_q, load_q;
  logic sck_d, csn_d, rd_d, so_d, pstb_d, vol_d, start_d, load_d;
  logic [5:0] cnt_q, cnt_d;
  logic [7:0] sh_q, sh_d, opc_q, opc_d, wrd_q, wrd_d, out_q, out_d, pbyte_q, pbyte_d;
  logic [23:0] adr_q, adr_d;
  fpsr_stat_s stat_q, stat_d;
  fpsr_state_e st_q, st_d;
  fpsr_op_s op_q, op_d;
  logic sck_rise, sck_fall, cs_rise, byte_done, busy, locked, exec_c, prot_hit;
  logic [7:0] new_byte, span, first_sect;
  logic [5:0] need;
  fpsr_kind_e kind;
  logic [2:0] idx;

  // Serial pins come from the host's clock, so they are resampled first.
  // Select and write-protect reset high, so no false select edge follows reset.
  fpsr_sync #(.W(4), .INIT(4'h5)) u_sync (
    .clk(REF_CLK),
    .rst(RST),
    .din({SCK, CS_N, SI, WP_N}),
    .dout(pin_s)
  );
  assign sck_s = pin_s[3];
  assign csn_s = pin_s[2];
  assign si_s = pin_s[1];
  assign wpn_s = pin_s[0];

  // Edge detection on the resampled link clock and chip select.
  assign sck_rise = sck_s & ~sck_q & ~csn_s;
  assign sck_fall = ~sck_s & sck_q & ~csn_s;
  assign cs_rise = csn_s & ~csn_q;
  assign byte_done = sck_rise & (cnt_q[2:0] == BYTE_LAST_BIT);
  assign new_byte = {sh_q[6:0], si_s};
  assign idx = cnt_q[5:3];
  assign busy = (st_q == ST_BUSY);
  assign kind = opc_kind(opc_q);

  // Status writes lock when the partner bit is set, or when bit 7 is set while the pin is low.
  assign locked = STATUS_PROTECT_HI | (stat_q.protect_lo & ~wpn_s);

  // Bit count each command needs; unknown opcodes never execute.
  always_comb begin
    case (opc_q)
      OPC_WREN, OPC_VWREN, OPC_CHIP_A, OPC_CHIP_B: need = BITS_OPC;
      OPC_WRSR: need = BITS_WRSR;
      OPC_ER4K, OPC_ER32K, OPC_ER64K: need = BITS_ADDR;
      OPC_PROG: need = BITS_PROG;
      default: need = '0;
    endcase
  end

  // A command acts only when chip select rises on a byte boundary after it is whole.
  assign exec_c = cs_rise & (cnt_q[2:0] == 3'h0) & (need != 6'h00)
    & (cnt_q >= need) & ~busy;

  // Sectors touched by the pending array command.
  always_comb begin
    case (kind)
      OPK_ER32K: span = SPAN_32K;
      OPK_ER64K: span = SPAN_64K;
      OPK_CHIP: span = SPAN_CHIP;
      default: span = SPAN_4K;
    endcase
  end
  assign first_sect = adr_q[19:12] & ~span;

  fpsr_protect u_protect (
    .granularity(stat_q.protect_granularity),
    .direction(stat_q.protect_direction),
    .level(stat_q.protect_level),
    .first_sect(first_sect),
    .last_sect(first_sect | span),
    .hit(prot_hit)
  );

  // Serial shifter: collects opcode, address and data, and drives status bytes out.
  always_comb begin
    sck_d = sck_s;
    csn_d = csn_s;
    cnt_d = cnt_q;
    sh_d = sh_q;
    opc_d = opc_q;
    adr_d = adr_q;
    wrd_d = wrd_q;
    rd_d = rd_q;
    so_d = so_q;
    out_d = out_q;
    pstb_d = 1'b0;
    pbyte_d = pbyte_q;
    if (csn_s) begin
      cnt_d = '0;
      rd_d = 1'b0;
    end else if (sck_rise) begin
      sh_d = new_byte;
      // The count parks in its last byte so long programs keep byte alignment.
      cnt_d = (cnt_q == CNT_TOP) ? (CNT_TOP - 6'h07) : (cnt_q + 6'h01);
    end
    if (byte_done) begin
      if (idx == IDX_OPC) begin
        opc_d = new_byte;
        rd_d = (new_byte == OPC_RDSR);
      end else if (idx < IDX_DATA) begin
        adr_d = {adr_q[15:0], new_byte};
      end else if (opc_kind(opc_q) == OPK_PROG && stat_q.write_enable_latch && !busy) begin
        pstb_d = 1'b1;
        pbyte_d = new_byte;
      end
      if (idx == IDX_WRSR) begin
        wrd_d = new_byte;
      end
    end
    // Each new byte boundary reloads the live register, so polling sees fresh data.
    if (sck_fall && rd_q) begin
      if (cnt_q[2:0] == 3'h0) begin
        so_d = stat_q[STAT_MSB];
        out_d = {stat_q[6:0], 1'b0};
      end else begin
        so_d = out_q[7];
        out_d = {out_q[6:0], 1'b0};
      end
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      sck_q <= 1'b0;
      csn_q <= 1'b1;
      cnt_q <= '0;
      sh_q <= '0;
      opc_q <= '0;
      adr_q <= '0;
      wrd_q <= '0;
      rd_q <= 1'b0;
      so_q <= 1'b0;
      out_q <= '0;
      pstb_q <= 1'b0;
      pbyte_q <= '0;
    end else begin
      sck_q <= sck_d;
      csn_q <= csn_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      opc_q <= opc_d;
      adr_q <= adr_d;
      wrd_q <= wrd_d;
      rd_q <= rd_d;
      so_q <= so_d;
      out_q <= out_d;
      pstb_q <= pstb_d;
      pbyte_q <= pbyte_d;
    end
  end

  // Register, enable latches and busy tracking.
  always_comb begin
    stat_d = stat_q;
    vol_d = vol_q;
    st_d = st_q;
    op_d = op_q;
    start_d = 1'b0;
    load_d = 1'b0;
    if (load_q) begin
      stat_d[STAT_MSB:FIELD_LSB] = NV_STATUS;
    end
    if (exec_c) begin
      case (opc_q)
        OPC_WREN: begin
          stat_d.write_enable_latch = 1'b1;
          vol_d = 1'b0;
        end
        OPC_VWREN: begin
          vol_d = 1'b1;
        end
        OPC_WRSR: begin
          if (stat_q.write_enable_latch || vol_q) begin
            if (!locked) begin
              stat_d[STAT_MSB:FIELD_LSB] = wrd_q[STAT_MSB:FIELD_LSB];
              // Only a latch-enabled write reaches the stored copy.
              if (stat_q.write_enable_latch) begin
                start_d = 1'b1;
                op_d = '{kind: OPK_NVSR, addr: '0, data: wrd_q};
              end
            end
            stat_d.write_enable_latch = 1'b0;
            vol_d = 1'b0;
          end
        end
        default: begin
          if (kind != OPK_NONE && stat_q.write_enable_latch) begin
            if (!prot_hit) begin
              start_d = 1'b1;
              op_d = '{kind: kind, addr: adr_q, data: '0};
            end
            stat_d.write_enable_latch = 1'b0;
          end
        end
      endcase
    end
    case (st_q)
      ST_READY: if (start_d) st_d = ST_BUSY;
      ST_BUSY: if (OP_DONE) st_d = ST_READY;
      default: st_d = ST_READY;
    endcase
    stat_d.busy_flag = (st_d == ST_BUSY);
  end

  // Reset gives a cleared register; the stored copy loads on the cycle after release.
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      stat_q <= STAT_RESET;
      vol_q <= 1'b0;
      st_q <= ST_READY;
      op_q <= '0;
      start_q <= 1'b0;
      load_q <= 1'b1;
    end else begin
      stat_q <= stat_d;
      vol_q <= vol_d;
      st_q <= st_d;
      op_q <= op_d;
      start_q <= start_d;
      load_q <= load_d;
    end
  end

  assign SO = so_q;
  assign SO_OE = rd_q;
  assign OP_START = start_q;
  assign OP = op_q;
  assign PROG_STB = pstb_q;
  assign PROG_BYTE = pbyte_q;
  assign STATUS = stat_q;

  property p_wel_set;
    @(posedge REF_CLK) disable iff (RST)
      (exec_c && opc_q == OPC_WREN) |=> stat_q.write_enable_latch;
  endproperty
  a_wel_set: assert property (p_wel_set) else $error("write enable did not set latch");

  property p_vwel_keep;
    @(posedge REF_CLK) disable iff (RST)
      (exec_c && opc_q == OPC_VWREN) |=> $stable(stat_q.write_enable_latch);
  endproperty
  a_vwel_keep: assert property (p_vwel_keep) else $error("volatile enable moved latch");

  property p_reset_clear;
    @(posedge REF_CLK) $past(RST) |-> !stat_q.write_enable_latch && !stat_q.busy_flag;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("latch not clear after reset");

  property p_level_reset;
    @(posedge REF_CLK) $past(RST) |-> stat_q.protect_level == LEVEL_NONE;
  endproperty
  a_level_reset: assert property (p_level_reset) else $error("level not zero after reset");

  property p_incomplete;
    @(posedge REF_CLK) disable iff (RST)
      (cs_rise && !exec_c && !busy) |=> $stable(stat_q.write_enable_latch);
  endproperty
  a_incomplete: assert property (p_incomplete) else $error("aborted command moved latch");

  property p_start_needs_wel;
    @(posedge REF_CLK) disable iff (RST)
      OP_START |-> $past(stat_q.write_enable_latch) && !stat_q.write_enable_latch;
  endproperty
  a_start_needs_wel: assert property (p_start_needs_wel) else $error("op without latch");

  property p_protected;
    @(posedge REF_CLK) disable iff (RST) (OP_START && OP.kind != OPK_NVSR) |-> !$past(prot_hit);
  endproperty
  a_protected: assert property (p_protected) else $error("protected area op started");

  property p_busy;
    @(posedge REF_CLK) disable iff (RST)
      (OP_START |-> stat_q.busy_flag) and ($fell(stat_q.busy_flag) |-> $past(OP_DONE));
  endproperty
  a_busy: assert property (p_busy) else $error("busy flag out of step");

  property p_fields_written;
    @(posedge REF_CLK) disable iff (RST) !$stable(stat_q[STAT_MSB:FIELD_LSB])
      |-> $past(load_q) || ($past(exec_c) && $past(opc_q) == OPC_WRSR && !$past(locked));
  endproperty
  a_fields_written: assert property (p_fields_written) else $error("fields changed");

  property p_volatile_only;
    @(posedge REF_CLK) disable iff (RST)
      (exec_c && opc_q == OPC_WRSR && !stat_q.write_enable_latch) |=> !OP_START;
  endproperty
  a_volatile_only: assert property (p_volatile_only) else $error("volatile write stored");

  property p_read_msb;
    @(posedge REF_CLK) disable iff (RST)
      (sck_fall && rd_q && cnt_q[2:0] == 3'h0) |=> SO == $past(stat_q.protect_lo);
  endproperty
  a_read_msb: assert property (p_read_msb) else $error("status byte not shifted out");
endmodule
`default_nettype wire

// ==== inc/fpsr_pkg.sv ====
// Constants, types and helpers shared by the primary flash status register block.
// Summary of operation
// - Bit 7 with partner bit and pin locks writes
// - Bit 5 protects from bottom or top
// - Bits 4:2 protect level, set by 01h only
// - Protect level resets to zero, nothing protected
// - Program or erase into protected area refused
// - Latch clear blocks program, erase, status writes
// - Latch cleared at power-up and reset
// - Incomplete command leaves latch untouched
// - Latch cleared only after complete write command
// - Opcode 06h sets the latch
// - Opcode 50h leaves the latch as is
// - Bit 0 high while internal operation runs
// - Opcode 05h shifts the register out
// - Volatile status write skips non-volatile copy
`default_nettype none
package fpsr_pkg;
  // Opcodes decoded by the block.
  localparam logic [7:0] OPC_WREN = 8'h06;
  localparam logic [7:0] OPC_VWREN = 8'h50;
  localparam logic [7:0] OPC_RDSR = 8'h05;
  localparam logic [7:0] OPC_WRSR = 8'h01;
  localparam logic [7:0] OPC_PROG = 8'h02;
  localparam logic [7:0] OPC_ER4K = 8'h20;
  localparam logic [7:0] OPC_ER32K = 8'h52;
  localparam logic [7:0] OPC_ER64K = 8'hd8;
  localparam logic [7:0] OPC_CHIP_A = 8'hc7;
  localparam logic [7:0] OPC_CHIP_B = 8'h60;
  // Bit counts a command needs before it may execute.
  localparam logic [5:0] BITS_OPC = 6'h08;
  localparam logic [5:0] BITS_WRSR = 6'h10;
  localparam logic [5:0] BITS_ADDR = 6'h20;
  localparam logic [5:0] BITS_PROG = 6'h28;
  localparam logic [5:0] CNT_TOP = 6'h2f;
  localparam logic [2:0] BYTE_LAST_BIT = 3'h7;
  localparam logic [2:0] IDX_OPC = 3'h0;
  localparam logic [2:0] IDX_WRSR = 3'h1;
  localparam logic [2:0] IDX_DATA = 3'h4;
  // Register layout and values.
  localparam int STAT_MSB = 7;
  localparam int FIELD_LSB = 2;
  localparam logic [2:0] LEVEL_NONE = 3'h0;
  localparam logic [2:0] LEVEL_ALL = 3'h7;
  localparam logic [7:0] STAT_RESET = 8'h00;
  // Protection geometry in 4 kB sectors.
  localparam logic [9:0] SECT_TOTAL = 10'h100;
  localparam logic [9:0] UNIT_SMALL = 10'h001;
  localparam logic [9:0] UNIT_LARGE = 10'h010;
  localparam logic [7:0] SPAN_4K = 8'h00;
  localparam logic [7:0] SPAN_32K = 8'h07;
  localparam logic [7:0] SPAN_64K = 8'h0f;
  localparam logic [7:0] SPAN_CHIP = 8'hff;

  typedef enum logic [2:0] {
    OPK_NONE = 3'h0, OPK_PROG = 3'h1, OPK_ER4K = 3'h2, OPK_ER32K = 3'h3,
    OPK_ER64K = 3'h4, OPK_CHIP = 3'h5, OPK_NVSR = 3'h6
  } fpsr_kind_e;

  typedef enum logic [1:0] {
    ST_READY = 2'b01,
    ST_BUSY = 2'b10
  } fpsr_state_e;

  typedef struct packed {
    logic protect_lo;
    logic protect_granularity;
    logic protect_direction;
    logic [2:0] protect_level;
    logic write_enable_latch;
    logic busy_flag;
  } fpsr_stat_s;

  typedef struct packed {
    fpsr_kind_e kind;
    logic [23:0] addr;
    logic [7:0] data;
  } fpsr_op_s;

  // Array operation selected by an opcode.
  function automatic fpsr_kind_e opc_kind(input logic [7:0] opc);
    case (opc)
      OPC_PROG: opc_kind = OPK_PROG;
      OPC_ER4K: opc_kind = OPK_ER4K;
      OPC_ER32K: opc_kind = OPK_ER32K;
      OPC_ER64K: opc_kind = OPK_ER64K;
      OPC_CHIP_A, OPC_CHIP_B: opc_kind = OPK_CHIP;
      default: opc_kind = OPK_NONE;
    endcase
  endfunction
endpackage
`default_nettype wire

// ==== hdl/fpsr_sync.sv ====
// Two-stage synchroniser for pins that arrive from outside the reference clock.
`timescale 1ns/1ns
`default_nettype none
module fpsr_sync #(
  parameter int W = 4,
  // Reset value of both stages; it should match the idle level of each pin.
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] dout_d;

  // The first stage feeds only the second stage.
  always_comb begin
    meta_d = din;
    dout_d = meta_q;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q <= INIT;
      dout <= INIT;
    end else begin
      meta_q <= meta_d;
      dout <= dout_d;
    end
  end
endmodule
`default_nettype wire

// ==== hdl/fpsr_protect.sv ====
// Decides whether a sector range falls inside the block-protected region.
`timescale 1ns/1ns
`default_nettype none
module fpsr_protect
  import fpsr_pkg::*;
(
  input wire logic granularity,
  input wire logic direction,
  input wire logic [2:0] level,
  input wire logic [7:0] first_sect,
  input wire logic [7:0] last_sect,
  output logic hit
);
  logic [9:0] units;

  // Region size in sectors, capped at the whole array.
  always_comb begin
    if (level == LEVEL_NONE) begin
      units = '0;
    end else if (level == LEVEL_ALL) begin
      units = SECT_TOTAL;
    end else if (granularity) begin
      units = UNIT_SMALL << (level - 3'h1);
    end else begin
      units = UNIT_LARGE << (level - 3'h1);
    end
    if (units > SECT_TOTAL) begin
      units = SECT_TOTAL;
    end
    // Top-down regions end at the last sector, bottom-up start at sector zero.
    if (direction) begin
      hit = ({2'b00, last_sect} + units) >= SECT_TOTAL;
    end else begin
      hit = {2'b00, first_sect} < units;
    end
  end
endmodule
`default_nettype wire

// ==== verification/fpsr_host.sv ====
// Serial host model that clocks command frames into the status register block.
`timescale 1ns/1ns
`default_nettype none
module fpsr_host (
  input wire logic clk,
  input wire logic so,
  output logic sck,
  output logic cs_n,
  output logic si
);
  // Bus parked between frames: clock low, select high.
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
  end

  // Wait whole reference cycles, then step just past the edge.
  task automatic hw(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask

  // Mode 0 frame: data is set while the clock is low and read back at the rising edge.
  task automatic xfer(input logic [7:0] tx[$], input int nb, output logic [7:0] rx);
    int i;
    rx = 8'h00;
    hw(1);
    cs_n = 1'b0;
    for (i = 0; i < nb; i++) begin
      si = tx[i / 8][7 - i % 8];
      hw(4);
      sck = 1'b1;
      rx = {rx[6:0], so};
      hw(4);
      sck = 1'b0;
    end
    hw(4);
    cs_n = 1'b1;
    // Released data line flips so that a stale bit is never mistaken for a driven one.
    si = ~si;
    hw(10);
  endtask
endmodule
`default_nettype wire

// ==== verification/tb_top.sv ====
// Self-checking bench for the primary status register with a reference model.
`timescale 1ns/1ns
`default_nettype none
module tb_top
  import fpsr_pkg::*;
;
  logic clk, rst, sck, cs_n, si, wp_n, prot_hi, so, so_oe, op_start, prog_stb;
  logic op_done = 1'b0;
  logic [5:0] nv;
  logic [7:0] status, prog_byte, p_byte, rx;
  fpsr_op_s op;
  int errors, check_count, starts, m_starts, bsy_cnt;
  logic [31:0] seed = 32'hf7c1be7a;
  logic [5:0] m_f;
  logic m_wel, m_v, m_busy;

  // Reference clock at 20 MHz.
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  fpsr_top dut_u (.REF_CLK(clk), .RST(rst), .SCK(sck), .CS_N(cs_n), .SI(si), .WP_N(wp_n),
    .STATUS_PROTECT_HI(prot_hi), .NV_STATUS(nv), .OP_DONE(op_done), .SO(so), .SO_OE(so_oe),
    .OP_START(op_start), .OP(op), .PROG_STB(prog_stb), .PROG_BYTE(prog_byte),
    .STATUS(status));
  fpsr_host host_u (.clk(clk), .so(so), .sck(sck), .cs_n(cs_n), .si(si));

  // Array sequencer stand-in; the long busy time lets a command land while busy.
  always @(posedge clk) begin
    op_done <= #2 (bsy_cnt == 1);
    if (prog_stb === 1'b1) p_byte <= prog_byte;
    if (rst) bsy_cnt <= 0;
    else if (op_start === 1'b1) begin
      starts <= starts + 1;
      bsy_cnt <= 300;
    end else if (bsy_cnt > 0) begin
      bsy_cnt <= bsy_cnt - 1;
      if (bsy_cnt == 1) m_busy <= 1'b0;
    end
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Protected sector span from the fields; size is capped at the whole array.
  function automatic logic hit(input logic [5:0] f, input int lo, input int hi);
    int sz;
    sz = (f[2:0] == 3'h7) ? 256 : (f[2:0] == 3'h0) ? 0 : ((f[4] ? 1 : 16) << (f[2:0] - 1));
    if (sz > 256) sz = 256;
    return f[3] ? (hi >= 256 - sz) : (lo < sz);
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic do_reset();
    rst = 1'b1;
    repeat (3) @(posedge clk);
    #2 rst = 1'b0;
    repeat (6) @(posedge clk);
    #2;
    m_f = nv;
    m_wel = 1'b0;
    m_v = 1'b0;
    m_busy = 1'b0;
    chk(status, {nv, 2'b00}, "reset");
  endtask

  // Sends one frame, steps the model, then compares starts, op and register.
  task automatic cmd(input logic [7:0] tx[$], input int nb);
    logic lk;
    logic [2:0] ek;
    int sp;
    int lo;
    logic [7:0] o;
    host_u.xfer(tx, nb, rx);
    o = tx[0];
    ek = OPK_NONE;
    sp = -1;
    lk = prot_hi | (m_f[5] & ~wp_n);
    if (nb % 8 == 0 && !m_busy) begin
      if (nb == 8 && o == OPC_WREN) m_wel = 1'b1;
      if (nb == 8 && o == OPC_VWREN) m_v = 1'b1;
      if (nb == 16 && o == OPC_WRSR && (m_wel | m_v)) begin
        if (!lk) m_f = tx[1][7:2];
        if (!lk && m_wel) ek = OPK_NVSR;
        m_wel = 1'b0;
        m_v = 1'b0;
      end
      if (o == OPC_PROG && nb >= 40) sp = 0;
      if (o == OPC_ER4K && nb == 32) sp = 0;
      if (o == OPC_ER32K && nb == 32) sp = 7;
      if (o == OPC_ER64K && nb == 32) sp = 15;
      if ((o == OPC_CHIP_A || o == OPC_CHIP_B) && nb == 8) sp = 255;
      if (sp >= 0 && m_wel) begin
        lo = (sp == 255) ? 0 : (int'({tx[1][3:0], tx[2][7:4]}) & ~sp);
        if (!hit(m_f, lo, lo + sp)) begin
          ek = (o == OPC_PROG) ? OPK_PROG : (o == OPC_ER4K) ? OPK_ER4K :
            (o == OPC_ER32K) ? OPK_ER32K : (o == OPC_ER64K) ? OPK_ER64K : OPK_CHIP;
        end
        m_wel = 1'b0;
      end
    end
    if (ek != OPK_NONE) begin
      m_starts++;
      m_busy = 1'b1;
    end
    chk(starts, m_starts, "start count");
    if (ek != OPK_NONE) chk(op.kind, ek, "op kind");
    if (ek == OPK_NVSR) chk(op.data, tx[1], "store data");
    else if (ek != OPK_NONE && sp != 255) chk(op.addr, {tx[1], tx[2], tx[3]}, "addr");
    if (ek == OPK_PROG) chk(p_byte, tx[4], "prog byte");
    chk(status, {m_f, m_wel, m_busy}, "status");
  endtask

  // Fresh status bytes are read until the busy bit falls.
  task automatic poll();
    int n;
    for (n = 0; n < 30; n++) begin
      host_u.xfer('{OPC_RDSR, 8'h00}, 16, rx);
      chk(rx[7:1], {m_f, m_wel}, "read");
      chk(so_oe, 1'b0, "so release");
      if (rx[0] === 1'b0) break;
    end
    if (n == 30) begin
      errors++;
      complete_run();
    end
    chk(status, {m_f, m_wel, 1'b0}, "ready");
  endtask

  // Main sequence.
  initial begin
    int i;
    logic [31:0] r, a;
    logic [7:0] o;
    logic [7:0] ops[6];
    ops = '{OPC_PROG, OPC_ER4K, OPC_ER32K, OPC_ER64K, OPC_CHIP_A, OPC_CHIP_B};
    wp_n = 1'b1;
    prot_hi = 1'b0;
    r = rnd();
    nv = r[5:0];
    do_reset();
    $display("test reset done");
    cmd('{OPC_WRSR, 8'hfc}, 16);
    cmd('{OPC_WREN}, 8);
    cmd('{OPC_WRSR}, 4);
    cmd('{8'h9f}, 8);
    r = rnd();
    cmd('{OPC_WRSR, r[7:0]}, 16);
    cmd('{OPC_WREN}, 8);
    poll();
    cmd('{OPC_VWREN}, 8);
    cmd('{OPC_WRSR, 8'h03}, 16);
    $display("test status writes done");
    for (i = 0; i < 14; i++) begin
      r = rnd();
      a = rnd();
      o = ops[r[10:8] % 6];
      cmd('{OPC_VWREN}, 8);
      cmd('{OPC_WRSR, {1'b0, r[6:0]}}, 16);
      cmd('{OPC_WREN}, 8);
      cmd('{o, {4'h0, a[19:16]}, a[15:8], a[7:0], a[31:24]},
        (o == OPC_PROG) ? 40 : (o == OPC_CHIP_A || o == OPC_CHIP_B) ? 8 : 32);
      poll();
    end
    $display("test protection done");
    prot_hi = 1'b1;
    cmd('{OPC_VWREN}, 8);
    cmd('{OPC_WRSR, 8'h1c}, 16);
    prot_hi = 1'b0;
    cmd('{OPC_VWREN}, 8);
    cmd('{OPC_WRSR, 8'h80}, 16);
    wp_n = 1'b0;
    cmd('{OPC_WREN}, 8);
    cmd('{OPC_WRSR, 8'h04}, 16);
    wp_n = 1'b1;
    $display("test lock done");
    cmd('{OPC_WREN}, 8);
    do_reset();
    $display("test mid reset done");
    complete_run();
  end
endmodule
`default_nettype wire
